// File: hdl/apo_port.sv
// What this block does
// - convert on rising convert clock edge only
// - results in straight offset binary code
// - first output bit msb, last lsb
// - output enable high floats data outputs
// - result appears six convert edges later
// - over-range flag set above full scale or below zero
`timescale 1ns/1ns
module apo_port
  import apo_pkg::*;
#(
  parameter int W = RESULT_W,
  parameter int LAT = LATENCY,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // convert clock pin and output enable pin, active low
  input wire logic conv_clk,
  input wire logic out_en_n,
  // sampled value from the quantiser, as a straight offset binary code
  input wire logic samp_valid,
  output logic samp_ready,
  input wire logic [W-1:0] samp_code,
  input wire logic samp_above,
  input wire logic samp_below,
  // parallel outputs, index 0 is the first pin (msb)
  output logic [W-1:0] result_bit_o,
  output logic [W-1:0] result_bit_oe,
  output logic over_range_flag,
  output logic over_range_flag_oe
);
  logic [SYNC_STAGES-1:0] clk_sync_q;
  logic [SYNC_STAGES-1:0] clk_sync_d;
  logic [SYNC_STAGES-1:0] oe_sync_q;
  logic [SYNC_STAGES-1:0] oe_sync_d;
  logic clk_prev_q, clk_prev_d;
  logic rise;
  logic [W:0] pipe_q [LAT];
  logic [W:0] pipe_d [LAT];
  logic [W-1:0] code_sat;
  logic ovr_now;
  logic f_valid, f_ready;
  logic [W:0] f_data;
  logic [W:0] out_q, out_d;
  logic [W:0] in_word;

  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  always_comb begin
    clk_sync_d = {clk_sync_q[SYNC_STAGES-2:0], conv_clk};
    oe_sync_d = {oe_sync_q[SYNC_STAGES-2:0], out_en_n};
    clk_prev_d = clk_sync_q[SYNC_STAGES-1];
    rise = clk_sync_q[SYNC_STAGES-1] && !clk_prev_q;
  end

  // ----------------------------------------
  // sample buffer
  // ----------------------------------------
  apo_fifo #(.WIDTH(W+1), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(samp_valid),
    .in_ready(samp_ready),
    .in_data(in_word),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // ----------------------------------------
  // coding and pipeline
  // ----------------------------------------
  always_comb begin
    // out of range clamps to the nearest end of the code range
    in_word = {samp_above || samp_below, samp_code};
    if (samp_above) begin
      in_word[W-1:0] = CODE_FULL;
    end else if (samp_below) begin
      in_word[W-1:0] = CODE_ZERO;
    end
    f_ready = rise;
    ovr_now = f_valid && f_data[W];
    code_sat = f_valid ? f_data[W-1:0] : CODE_ZERO;
    pipe_d = pipe_q;
    if (rise) begin
      pipe_d[0] = {ovr_now, code_sat};
      for (int i = 1; i < LAT; i++) begin
        pipe_d[i] = pipe_q[i-1];
      end
    end
    // the last stage reaches the pins on the next convert edge
    out_d = rise ? pipe_q[LAT-1] : out_q;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clk_sync_q <= '0;
      oe_sync_q <= {SYNC_STAGES{OE_N_RESET}};
      clk_prev_q <= 1'b0;
      out_q <= '0;
      for (int i = 0; i < LAT; i++) begin
        pipe_q[i] <= '0;
      end
    end else begin
      clk_sync_q <= clk_sync_d;
      oe_sync_q <= oe_sync_d;
      clk_prev_q <= clk_prev_d;
      out_q <= out_d;
      pipe_q <= pipe_d;
    end
  end

  // ----------------------------------------
  // output pins
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < W; i++) begin
      result_bit_o[i] = out_q[W-1-i];
    end
    result_bit_oe = {W{!oe_sync_q[SYNC_STAGES-1]}};
    over_range_flag = out_q[W];
    over_range_flag_oe = 1'b1;
  end
endmodule

// File: hdl/apo_pkg.sv
package apo_pkg;
  // result width and pipeline latency in convert clock cycles
  localparam int RESULT_W = 12;
  localparam int LATENCY = 6;
  // sample rate limits in samples per second
  localparam int RATE_MIN_SPS = 10000;
  localparam int RATE_MAX_SPS = 10000000;
  localparam int CLK_HZ = 100000000;
  // shortest convert period in core clock cycles
  localparam int CONV_PERIOD_MIN_CYC = CLK_HZ / RATE_MAX_SPS;
  localparam int FIFO_DEPTH = 32;
  localparam int SYNC_STAGES = 2;
  // code limits and reset values
  localparam logic [RESULT_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [RESULT_W-1:0] CODE_FULL = 12'hfff;
  localparam logic OE_N_RESET = 1'b0;
endpackage

// File: hdl/apo_fifo.sv
`timescale 1ns/1ns
module apo_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // ----------------------------------------
  // pointers and storage
  // ----------------------------------------
  always_comb begin
    in_ready = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data = mem_q[rd_q];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    mem_d = mem_q;
    if (push) begin
      mem_d[wr_q] = in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule

// File: test/apo_cap.sv
`timescale 1ns/1ns
// ----
// capture side: convert clock, idle low when stopped
// ----
module apo_cap (
  // clock, reset, run request
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic run,
  // convert clock pin
  output logic conv_clk
);
  logic [3:0] cnt_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= (run || cnt_q != 4'h0) ? ((cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1) : 4'h0;
    end
  end
  assign conv_clk = cnt_q > 4'h4;
endmodule

// File: test/apo_port_monitor.sv
`timescale 1ns/1ns
// ----
// output pin checks
// ----
module apo_port_monitor
  import apo_pkg::*;
(
  // watched pins
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic conv_clk,
  input wire logic out_en_n,
  input wire logic [RESULT_W-1:0] result_bit_o,
  input wire logic [RESULT_W-1:0] result_bit_oe,
  input wire logic over_range_flag,
  input wire logic over_range_flag_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence conv_quiet;
    !conv_clk [*5];
  endsequence
  a_hold_no_edge: assert property (conv_quiet |-> $stable(result_bit_o))
    else $error("data changed without convert edge");
  a_flag_with_data: assert property (conv_quiet |-> $stable(over_range_flag))
    else $error("flag changed without convert edge");
  a_float_when_high: assert property (out_en_n [*3] |-> result_bit_oe == '0)
    else $error("data driven while disabled");
  a_drive_when_low: assert property (!out_en_n [*3] |-> result_bit_oe == '1)
    else $error("data floats while enabled");
  a_flag_driven: assert property (over_range_flag_oe)
    else $error("flag not driven");
  a_flag_code_limit: assert property (over_range_flag |-> result_bit_o inside {'0, '1})
    else $error("flag set with inner code");
endmodule
bind apo_port apo_port_monitor apo_port_monitor_inst (.core_clk, .rstn, .conv_clk, .out_en_n,
  .result_bit_o, .result_bit_oe, .over_range_flag, .over_range_flag_oe);

// File: test/test_adc_parallel_output_port.sv
`timescale 1ns/1ns
module test_adc_parallel_output_port;
  import apo_pkg::*;
  logic core_clk = 0, rstn = 0, run = 0, out_en_n = 0, samp_valid = 0, samp_above = 0;
  logic samp_below = 0, conv_clk, samp_ready, over_range_flag, over_range_flag_oe;
  logic [11:0] samp_code = 12'h000, result_bit_o, result_bit_oe;
  logic [12:0] exp_q[$];
  int seed = 22, num_errors = 0, num_checks = 0, i, k;
  always #5 core_clk = ~core_clk;
  apo_cap apo_cap_inst (.core_clk, .rstn, .run, .conv_clk);
  apo_port apo_port_inst (.core_clk, .rstn, .conv_clk, .out_en_n, .samp_valid, .samp_ready,
    .samp_code, .samp_above, .samp_below, .result_bit_o, .result_bit_oe, .over_range_flag,
    .over_range_flag_oe);
  function automatic logic [12:0] expect_word(logic [11:0] c, logic a, logic b);
    return a ? 13'h1fff : b ? 13'h1000 : {1'b0, {<<{c}}};
  endfunction
  task automatic check(input logic [12:0] got, input logic [12:0] want);
    num_checks++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected at %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic complete_run;
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rstn = 1;
    for (i = 0; i < 32; i++) begin
      @(negedge core_clk);
      check(samp_ready, 1'b1);
      samp_valid = 1;
      samp_code = (i == 1 || i == 2) ? 12'hfff : (i < 4) ? 12'h000 : 12'($random(seed));
      samp_above = i == 2;
      samp_below = i == 3;
      exp_q.push_back(expect_word(samp_code, samp_above, samp_below));
    end
    @(negedge core_clk);
    samp_valid = 0;
    check(samp_ready, 1'b0);
    run = 1;
    for (i = 1; i <= 38; i++) begin
      for (k = 0; k < 30 && conv_clk !== 1'b1; k++) @(negedge core_clk);
      if (k == 30) begin
        num_errors++;
        complete_run;
      end
      repeat (8) @(negedge core_clk);
      check({over_range_flag, result_bit_o}, (i > 6) ? exp_q[i-7] : 13'h0000);
    end
    run = 0;
    out_en_n = 1;
    repeat (4) @(negedge core_clk);
    check(result_bit_oe, 12'h000);
    out_en_n = 0;
    repeat (4) @(negedge core_clk);
    check(result_bit_oe, 12'hfff);
    check(over_range_flag_oe, 1'b1);
    complete_run;
  end
endmodule
